// ### imch_checker.sv
`timescale 1ns/10ps
module imch_checker
  import imch_pkg::*;
#(
  parameter int NERR = EW
) (
  input wire logic             clk_sys,            // Clock
  input wire logic             reset,              // Sync reset
  input wire imch_byte_t       rxByte,             // Host byte
  input wire logic             slotTick,           // Slot pulse
  input wire logic             sampleTriggerInput, // Trigger pulse
  input wire imch_sample_t     compSample,         // Compensated data
  input wire imch_sample_t     trimOffset,         // Trim offsets
  input wire logic [NERR-1:0]  errNow,             // Live checks
  input wire imch_mode_t       mode,               // Mode
  input wire logic             sendMeas,           // Measurement send
  input wire imch_dg_t         sendSpecial,        // Special send
  input wire logic             sendUtilAck,        // Utility ack
  input wire logic             crcEnable,          // CRC on
  input wire logic             unitReset,          // Reset request
  input wire logic             txBusy,             // Datagram in flight
  input wire logic             sendInfoList,       // Service listing
  input wire imch_sample_t     adjSample,          // Trimmed data
  input wire logic [NERR-1:0]  diagReport          // Diagnostic
);
  imch_sample_t sumD;
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      sumD.axis[a] = compSample.axis[a] + trimOffset.axis[a];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence sCr;
    rxByte.valid && rxByte.data == CHAR_CR;
  endsequence
  sequence sSpecial;
    sendSpecial != DG_NONE;
  endsequence
  sequence sPendDone;
    mode == M_PENDSVC ##1 mode == M_SERVICE;
  endsequence
  chk_info_entry: assert property (
    sendInfoList |-> mode == M_SERVICE && $past(mode) != M_SERVICE)
    else $error("listing outside entry");
  chk_pend_info: assert property (
    sPendDone |-> sendInfoList) else $error("no listing after wait");
  chk_pend_hold: assert property (
    mode == M_PENDSVC && txBusy |=> mode == M_PENDSVC)
    else $error("service before datagram end");
  chk_trim_sum: assert property (
    !$past(reset) |-> adjSample == $past(sumD)) else $error("trim sum");
  chk_special_slot: assert property (
    sSpecial |-> $past(slotTick || sampleTriggerInput))
    else $error("special without slot");
  chk_special_once: assert property (
    sSpecial |=> sendSpecial == DG_NONE) else $error("special held");
  chk_special_meas: assert property (
    sSpecial |-> !sendMeas) else $error("special and meas together");
  chk_quiet_modes: assert property (
    (mode == M_SERVICE || mode == M_UTILITY) && $stable(mode)
    |-> !sendMeas && sendSpecial == DG_NONE) else $error("sent in console");
  chk_crc_mode: assert property (
    crcEnable == (mode == M_UTILITY)) else $error("crc not utility");
  chk_ack_cr: assert property (
    sendUtilAck |-> $past(rxByte.valid) && $past(rxByte.data) == CHAR_CR
    && mode == M_UTILITY) else $error("ack timing");
  chk_unit_reset: assert property (
    unitReset |-> sCr) else $error("reset not on CR");
  chk_init_rst: assert property (
    $past(reset) |-> mode == M_INIT) else $error("not init after reset");
  chk_diag_delay: assert property (
    !$past(reset) |-> diagReport == $past(errNow)) else $error("diag");
endmodule
bind imch_handler imch_checker #(.NERR(NERR)) i_chk (.*);

// ### imch_handler.sv
`timescale 1ns/10ps

// Summary of operation
// - Add per-axis trim offset after compensation
// - Trim offset always rate or acceleration
// - Send info listing on service entry
// - Service mode: sample on, no datagrams
// - External reset in service goes init
// - Service exit chooses init or normal
// - Utility traffic carries CRC-8 check
// - Utility entry: stop datagrams, acknowledge
// - Utility exit resumes normal datagrams
// - Status bits OR subsamples between sends
// - Status recomputed each send, unlatched
// - Clear error registers on three events
// - Decode N I C T E R keywords
// - CR executes, space separates parameter
// - No echo; act only on correct command
// - Special datagram replaces next slot(s)
// - External trigger sends special datagram
// - Drop increments during special datagram
// - Continuous checks, per-check diagnostic report
// - Finish current datagram before service entry
// - Ignore service entry with identifier over 255
module imch_handler
  import imch_pkg::*;
#(
  parameter int NERR = EW
) (
  input  wire logic                clk_sys,          // System clock
  input  wire logic                reset,            // Sync reset / external
  input  wire logic                powerOn,          // Power-on start pulse
  input  wire imch_byte_t          rxByte,           // Received host byte
  input  wire logic [7:0]          unitIdentifier,   // Own identifier
  input  wire logic                slotTick,         // Normal datagram slot
  input  wire logic                extTrigMode,      // Rate = external trig
  input  wire logic                sampleTriggerInput, // Trigger pulse
  input  wire logic                txBusy,           // Datagram in flight
  input  wire logic                incrementalMode,  // Incremental output
  input  wire imch_sample_t        compSample,       // Compensated data
  input  wire imch_sample_t        trimOffset,       // Trim, rate/accel
  input  wire logic                subsampleTick,    // Internal subsample
  input  wire logic [NERR-1:0]     errNow,           // Live check results
  input  wire logic                txDone,           // Datagram finished
  input  wire logic                svcExitCmd,       // Service exit pulse
  input  wire logic                svcExitToInit,    // Exit parameter
  input  wire logic                svcErrQuery,      // Accum-error query
  input  wire logic                utilExitCmd,      // Utility exit pulse
  input  wire logic                startupDone,      // Start-up complete
  output imch_mode_t               mode,             // Current mode
  output logic                     sendMeas,         // Send measurement
  output imch_dg_t                 sendSpecial,      // Special datagram
  output logic                     sendInfoList,     // Service listing
  output logic                     sendUtilAck,      // Utility acknowledge
  output logic                     crcEnable,        // CRC-8 on traffic
  output logic                     unitReset,        // Reset request
  output logic                     reloadConfig,     // Reload from flash
  output logic                     discardIncr,      // Drop increments
  output imch_sample_t             adjSample,        // Trimmed sample
  output logic [NERR-1:0]          statusBits,       // Per-send status
  output logic [NERR-1:0]          diagReport,       // Individual checks
  output logic [NERR-1:0]          extErr            // Extended errors
);

  // ==========================================================
  // Command parser
  logic [87:0] buf_q;
  logic [3:0]  len_q;
  logic        inParam_q;
  logic [9:0]  idVal_q;
  logic [1:0]  idCnt_q;
  logic        idBad_q;
  logic        isUpper;
  logic        isDigit;
  logic        isCr;
  logic        isSp;
  imch_dg_t    dgCmd;
  logic        humanCmd;
  logic        machineCmd;
  logic        resetCmd;

  assign isUpper = rxByte.data >= CHAR_UPA && rxByte.data <= CHAR_UPZ;
  assign isDigit = rxByte.data >= CHAR_ZERO && rxByte.data <= CHAR_NINE;
  assign isCr    = rxByte.valid && rxByte.data == CHAR_CR;
  assign isSp    = rxByte.valid && rxByte.data == CHAR_SP;

  always_comb begin
    dgCmd      = DG_NONE;
    resetCmd   = 1'b0;
    humanCmd   = 1'b0;
    machineCmd = 1'b0;
    if (isCr && mode == M_NORMAL) begin
      if (len_q == 4'h1 && !inParam_q) begin
        unique case (buf_q[7:0])
          CHAR_N: dgCmd = DG_PART;
          CHAR_I: dgCmd = DG_SERIAL;
          CHAR_C: dgCmd = DG_CONFIG;
          CHAR_T: dgCmd = DG_TRIM;
          CHAR_E: dgCmd = DG_EXTERR;
          CHAR_R: resetCmd = 1'b1;
          default: ;
        endcase
      end
      if (len_q == 4'(KEY_LEN)) begin
        // Identifier must be 0..255 with at least one digit
        humanCmd   = buf_q == KEY_HUMAN &&
                     (!inParam_q || (idCnt_q != 2'h0 && !idBad_q &&
                      idVal_q <= ID_MAX &&
                      idVal_q[7:0] == unitIdentifier));
        machineCmd = buf_q == KEY_MACHINE && !inParam_q;
      end
    end
  end

  // Upper-case letters accumulate, a space opens the parameter and digits follow it; anything else clears.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      buf_q     <= '0;
      len_q     <= LEN_RESET;
      inParam_q <= 1'b0;
      idVal_q   <= '0;
      idCnt_q   <= '0;
      idBad_q   <= 1'b0;
    end else if (rxByte.valid) begin
      if (isCr) begin
        buf_q     <= '0;
        len_q     <= LEN_RESET;
        inParam_q <= 1'b0;
        idVal_q   <= '0;
        idCnt_q   <= '0;
        idBad_q   <= 1'b0;
      end else if (isSp && !inParam_q && len_q != LEN_RESET) begin
        inParam_q <= 1'b1;
      end else if (inParam_q && isDigit) begin
        if (idCnt_q == 2'(ID_DIGITS))
          idBad_q <= 1'b1;
        else begin
          idVal_q <= 10'(idVal_q * 10'd10 + 10'(rxByte.data - CHAR_ZERO));
          idCnt_q <= idCnt_q + 2'h1;
        end
      end else if (!inParam_q && isUpper && len_q < 4'(KEY_LEN)) begin
        buf_q <= {buf_q[79:0], rxByte.data};
        len_q <= len_q + 4'h1;
      end else begin
        buf_q     <= '0;
        len_q     <= LEN_RESET;
        inParam_q <= 1'b0;
        idVal_q   <= '0;
        idCnt_q   <= '0;
        idBad_q   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Mode control
  imch_mode_t mode_q;
  assign mode = mode_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= M_INIT;
    end else begin
      unique case (mode_q)
        M_INIT:    if (startupDone) mode_q <= M_NORMAL;
        M_NORMAL: begin
          if (humanCmd)
            mode_q <= txBusy ? M_PENDSVC : M_SERVICE;
          else if (machineCmd)
            mode_q <= M_UTILITY;
        end
        M_PENDSVC: if (!txBusy) mode_q <= M_SERVICE;
        M_SERVICE: if (svcExitCmd)
          mode_q <= svcExitToInit ? M_INIT : M_NORMAL;
        M_UTILITY: if (utilExitCmd) mode_q <= M_NORMAL;
        default:   mode_q <= M_INIT;
      endcase
    end
  end

  // Reset reloads flash; a service exit to normal keeps edits.
  assign reloadConfig = mode_q == M_INIT;
  assign crcEnable    = mode_q == M_UTILITY;
  assign unitReset    = resetCmd;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sendInfoList <= 1'b0;
      sendUtilAck  <= 1'b0;
    end else begin
      sendInfoList <= mode_q != M_SERVICE &&
                      ((mode_q == M_NORMAL && humanCmd && !txBusy) ||
                       (mode_q == M_PENDSVC && !txBusy));
      sendUtilAck  <= mode_q == M_NORMAL && machineCmd;
    end
  end

  // ==========================================================
  // Datagram scheduling
  imch_dg_t pend_q;
  imch_dg_t special_q;
  logic     inSpecial_q;
  logic     slotNow;

  // Measurement only in normal mode; service/utility drop it.
  assign slotNow = mode_q == M_NORMAL &&
                   (extTrigMode ? sampleTriggerInput : slotTick);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_q      <= DG_NONE;
      special_q   <= DG_NONE;
      inSpecial_q <= 1'b0;
      sendMeas    <= 1'b0;
    end else begin
      sendMeas  <= 1'b0;
      special_q <= DG_NONE;
      if (dgCmd != DG_NONE)
        pend_q <= dgCmd;
      if (txDone)
        inSpecial_q <= 1'b0;
      // Slots arriving while a long special is out are lost.
      if (slotNow && !txBusy) begin
        if (dgCmd != DG_NONE || pend_q != DG_NONE) begin
          special_q   <= dgCmd != DG_NONE ? dgCmd : pend_q;
          pend_q      <= DG_NONE;
          inSpecial_q <= 1'b1;
        end else
          sendMeas <= 1'b1;
      end
    end
  end

  assign sendSpecial = special_q;
  assign discardIncr = incrementalMode && inSpecial_q;

  // ==========================================================
  // Trim: offsets already in rate/accel units for every mode
  wire [AXES-1:0][SW-1:0] trimSum;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : gTrim
      assign trimSum[g] = compSample.axis[g] +
                          trimOffset.axis[g];
    end
  endgenerate

  // One register process; per-axis processes would clash as drivers
  always_ff @(posedge clk_sys) begin
    if (reset)
      adjSample <= '0;
    else
      adjSample.axis <= trimSum;
  end

  // ==========================================================
  // Status and error accumulation
  logic [NERR-1:0] acc_q;
  logic            sentAny;
  logic            extSent;

  logic            lastExt_q;

  assign sentAny = sendMeas || special_q != DG_NONE;
  // A queued follow-up request must not hold off the clear
  assign extSent = txDone && inSpecial_q && lastExt_q;

  always_ff @(posedge clk_sys) begin
    if (reset)
      lastExt_q <= 1'b0;
    else if (special_q != DG_NONE)
      lastExt_q <= special_q == DG_EXTERR;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_q      <= '0;
      statusBits <= '0;
    end else if (sentAny) begin
      statusBits <= acc_q | errNow;
      acc_q      <= '0;
    end else if (subsampleTick)
      acc_q <= acc_q | errNow;
  end

  // Set wins over the clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset)
      extErr <= '0;
    else if (startupDone && mode_q == M_INIT || extSent ||
             (svcErrQuery && mode_q == M_SERVICE))
      extErr <= errNow;
    else
      extErr <= extErr | errNow;
  end

  // Checks run always; snapshot feeds the diagnostic command.
  always_ff @(posedge clk_sys) begin
    if (reset)
      diagReport <= '0;
    else
      diagReport <= errNow;
  end

endmodule

// ### imch_host.sv
`timescale 1ns/10ps
module imch_host
  import imch_pkg::*;
(
  input  wire logic clk_sys, // System clock
  output imch_byte_t rxByte  // Byte to device
);
  initial rxByte = '0;
  // ==========================================================
  // Command framing, callers pass any string, CR appended
  task automatic sendCmd(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge clk_sys);
      #1;
      rxByte.data = (i == s.len()) ? CHAR_CR : s[i];
      rxByte.valid = 1'b1;
      @(posedge clk_sys);
      #1;
      rxByte.valid = 1'b0;
      rxByte.data = ~rxByte.data; // Idle line shows no stale byte
    end
  endtask
endmodule

// ### imch_pkg.sv
package imch_pkg;

  // ==========================================================
  // Character codes
  localparam logic [7:0] CHAR_CR    = 8'h0D;
  localparam logic [7:0] CHAR_SP    = 8'h20;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] CHAR_NINE  = 8'h39;
  localparam logic [7:0] CHAR_UPA   = 8'h41;
  localparam logic [7:0] CHAR_UPZ   = 8'h5A;
  localparam logic [7:0] CHAR_N     = 8'h4E;
  localparam logic [7:0] CHAR_I     = 8'h49;
  localparam logic [7:0] CHAR_C     = 8'h43;
  localparam logic [7:0] CHAR_T     = 8'h54;
  localparam logic [7:0] CHAR_E     = 8'h45;
  localparam logic [7:0] CHAR_R     = 8'h52;

  // Keyword length and maximum identifier digits
  localparam int KEY_LEN    = 11;
  localparam int ID_DIGITS  = 3;
  localparam logic [9:0] ID_MAX = 10'h0FF;
  localparam logic [3:0] LEN_RESET = 4'h0;

  // Keywords, first character in the top byte
  localparam logic [87:0] KEY_HUMAN =
    {8'h53, 8'h45, 8'h52, 8'h56, 8'h49, 8'h43, 8'h45,
     8'h4D, 8'h4F, 8'h44, 8'h45};
  localparam logic [87:0] KEY_MACHINE =
    {8'h55, 8'h54, 8'h49, 8'h4C, 8'h49, 8'h54, 8'h59,
     8'h4D, 8'h4F, 8'h44, 8'h45};

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    DG_NONE   = 3'h0,
    DG_PART   = 3'h1,
    DG_SERIAL = 3'h2,
    DG_CONFIG = 3'h3,
    DG_TRIM   = 3'h4,
    DG_EXTERR = 3'h5
  } imch_dg_t;

  typedef enum logic [4:0] {
    M_NORMAL  = 5'b00001,
    M_PENDSVC = 5'b00010,
    M_SERVICE = 5'b00100,
    M_UTILITY = 5'b01000,
    M_INIT    = 5'b10000
  } imch_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } imch_byte_t;

  localparam int AXES = 6;
  localparam int SW   = 24;
  localparam int EW   = 8;

  typedef struct packed {
    logic [AXES-1:0][SW-1:0] axis;
  } imch_sample_t;

endpackage

// ### test_imu_mode_command_handler.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
 miscompares++; $display("Error %s expected %0h seen %0h", n, e, a); end end
module test_imu_mode_command_handler;
  import imch_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, slotTick = 0, extTrigMode = 0;
  logic sampleTriggerInput = 0, subsampleTick = 0, txDone = 0;
  logic svcExitCmd = 0, svcExitToInit = 0, utilExitCmd = 0;
  logic txBusy = 0, incrementalMode = 0, svcErrQuery = 0;
  logic startupDone = 0, sendMeas, sendInfoList, sendUtilAck;
  logic crcEnable, unitReset, reloadConfig, discardIncr;
  logic [7:0] unitIdentifier = 8'h05, errNow = 8'h00;
  logic [7:0] statusBits, diagReport, extErr;
  imch_sample_t compSample = '0, trimOffset = '0, adjSample;
  imch_mode_t mode;
  imch_dg_t sendSpecial;
  imch_byte_t rxByte;
  int miscompares = 0, checked = 0;
  int resetSeen = 0;
  imch_host i_host (.clk_sys, .rxByte);
  imch_handler i_dut (.clk_sys, .reset, .powerOn(1'b0), .rxByte,
    .unitIdentifier, .slotTick, .extTrigMode, .sampleTriggerInput,
    .txBusy, .incrementalMode, .compSample, .trimOffset,
    .subsampleTick, .errNow, .txDone, .svcExitCmd, .svcExitToInit,
    .svcErrQuery, .utilExitCmd, .startupDone, .mode, .sendMeas,
    .sendSpecial, .sendInfoList, .sendUtilAck, .crcEnable, .unitReset,
    .reloadConfig, .discardIncr, .adjSample, .statusBits, .diagReport,
    .extErr);
  always #5 clk_sys = ~clk_sys;
  // Reset request is a one-cycle combinational pulse; count it
  always @(posedge clk_sys) if (unitReset === 1'b1) resetSeen++;
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic slot();
    slotTick = 1;
    tick();
    slotTick = 0;
  endtask
  // ==========================================================
  // Bounded waits
  task automatic waitMode(imch_mode_t e);
    int k;
    for (k = 0; k < 40 && mode !== e; k++) tick();
    `CHK("mode", e, mode)
    if (k == 40) end_sim();
  endtask
  task automatic waitAck(bit util);
    int k;
    for (k = 0; k < 40 && (util ? sendUtilAck : sendInfoList) !== 1; k++)
      tick();
    `CHK("ack", 1'b1, util ? sendUtilAck : sendInfoList)
    if (k == 40) end_sim();
  endtask
  task automatic boot();
    reset = 1;
    tick(3);
    reset = 0;
    tick();
    `CHK("reloadConfig", 1'b1, reloadConfig)
    startupDone = 1;
    tick();
    startupDone = 0;
    waitMode(M_NORMAL);
    `CHK("extErr", 8'h00, extErr)
  endtask
  task automatic tTrim();
    for (int a = 0; a < AXES; a++) begin
      compSample.axis[a] = 24'h7FFFF0 + 24'(a);
      trimOffset.axis[a] = 24'h000020 - 24'(2 * a);
    end
    tick(2);
    for (int a = 0; a < AXES; a++)
      `CHK("adjSample", 24'(24'h800010 - a), adjSample.axis[a])
    $display("tTrim done");
  endtask
  task automatic tSpecials();
    string c = "NICTE";
    for (int i = 0; i < 5; i++) begin
      i_host.sendCmd(c.substr(i, i));
      slot();
      `CHK("sendSpecial", imch_dg_t'(i + 1), sendSpecial)
      `CHK("sendMeas", 1'b0, sendMeas)
    end
    i_host.sendCmd("n"); // Lower case must be ignored
    i_host.sendCmd("NN");
    slot();
    `CHK("sendSpecial", DG_NONE, sendSpecial)
    `CHK("sendMeas", 1'b1, sendMeas)
    i_host.sendCmd("I");
    extTrigMode = 1;
    sampleTriggerInput = 1;
    tick();
    sampleTriggerInput = 0;
    extTrigMode = 0;
    `CHK("trigSpecial", DG_SERIAL, sendSpecial)
    i_host.sendCmd("R");
    `CHK("unitReset", 1, resetSeen)
    $display("tSpecials done");
  endtask
  task automatic tErrors();
    errNow = 8'h01;
    subsampleTick = 1;
    tick();
    errNow = 8'h04;
    tick();
    errNow = 8'h00;
    subsampleTick = 0;
    slot();
    tick();
    `CHK("statusBits", 8'h05, statusBits)
    `CHK("extErr", 8'h05, extErr)
    slot();
    tick();
    `CHK("statusBits", 8'h00, statusBits)
    incrementalMode = 1;
    i_host.sendCmd("E");
    slot();
    `CHK("sendSpecial", DG_EXTERR, sendSpecial)
    tick();
    `CHK("discardIncr", 1'b1, discardIncr)
    txDone = 1;
    tick();
    txDone = 0;
    tick();
    `CHK("extErr", 8'h00, extErr)
    `CHK("discardIncr", 1'b0, discardIncr)
    incrementalMode = 0;
    $display("tErrors done");
  endtask
  task automatic tConsoles();
    string hk = $sformatf("%s", KEY_HUMAN);
    string mk = $sformatf("%s", KEY_MACHINE);
    i_host.sendCmd(mk);
    waitAck(1);
    `CHK("crcEnable", 1'b1, crcEnable)
    utilExitCmd = 1;
    tick();
    utilExitCmd = 0;
    waitMode(M_NORMAL);
    slot();
    `CHK("sendMeas", 1'b1, sendMeas)
    // 261 aliases the own identifier in its low byte
    i_host.sendCmd({hk, " 261"});
    tick(4);
    `CHK("mode", M_NORMAL, mode)
    txBusy = 1;
    i_host.sendCmd({hk, " 5"});
    `CHK("mode", M_PENDSVC, mode)
    `CHK("sendInfoList", 1'b0, sendInfoList)
    txBusy = 0;
    waitAck(0);
    waitMode(M_SERVICE);
    slot();
    `CHK("sendMeas", 1'b0, sendMeas)
    errNow = 8'h02;
    tick();
    errNow = 8'h00;
    `CHK("extErr", 8'h02, extErr)
    svcErrQuery = 1;
    tick();
    svcErrQuery = 0;
    `CHK("extErr", 8'h00, extErr)
    svcExitCmd = 1;
    tick();
    svcExitCmd = 0;
    waitMode(M_NORMAL);
    i_host.sendCmd(hk);
    waitMode(M_SERVICE);
    svcExitToInit = 1;
    svcExitCmd = 1;
    tick();
    svcExitCmd = 0;
    svcExitToInit = 0;
    `CHK("mode", M_INIT, mode)
    `CHK("reloadConfig", 1'b1, reloadConfig)
    boot();
    i_host.sendCmd(hk);
    waitMode(M_SERVICE);
    boot();
    $display("tConsoles done");
  endtask
  initial begin
    boot();
    tTrim();
    tSpecials();
    tErrors();
    tConsoles();
    end_sim();
  end
endmodule
